// File: design/shp_pkg.sv
// Package with constants shared by the serial host port
`default_nettype none
package shp_pkg;
  localparam int SHP_ADDR_W = 7;
  localparam int SHP_DATA_W = 8;
  localparam int SHP_BIT_CNT_W = 3;
  localparam logic [2:0] SHP_LAST_BIT = 3'h7;
  localparam logic [2:0] SHP_BIT_RESET = 3'h0;
  localparam logic [6:0] SHP_ADDR_RESET = 7'h00;
  localparam logic [7:0] SHP_BYTE_RESET = 8'h00;
  // Select and host mode stages start at their idle high level, clock and data low
  localparam logic [3:0] SHP_PIN_SYNC_RESET = 4'hC;
  localparam logic SHP_DIR_WRITE = 1'b0;
  localparam int SHP_CMD_DIR_BIT = 7;
  localparam int SHP_SYNC_STAGES = 2;
  localparam real SHP_MAX_RATE_MBPS = 40.0;
  localparam real SHP_CLK_MHZ = 125.0;
  localparam int SHP_MIN_HALF_CYCLES = int'(SHP_CLK_MHZ / SHP_MAX_RATE_MBPS / 2.0);
  typedef enum logic [1:0] {
    SHP_ST_CMD = 2'b00,
    SHP_ST_DUMMY = 2'b01,
    SHP_ST_DATA = 2'b10
  } shp_state_t;
endpackage
`default_nettype wire

// File: design/shp_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`default_nettype none
module shp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_VAL;
      q_reg <= RESET_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end
  assign q_o = q_reg;
endmodule
`default_nettype wire

// File: design/shp_host_port.sv
// Serial host register port: four-wire serial slave giving register read and write access
`default_nettype none
module shp_host_port
  import shp_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic host_port_select_i,
  input wire logic cs_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_n_o,
  output logic [SHP_ADDR_W-1:0] reg_addr_o,
  output logic [SHP_DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [SHP_DATA_W-1:0] reg_rdata_i
);
  logic rst_meta_reg;
  logic rst_n_reg;
  logic [3:0] pins_sync;
  logic sel_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_d_reg;
  shp_state_t state_reg;
  shp_state_t state_next;
  logic [SHP_BIT_CNT_W-1:0] bit_reg;
  logic [SHP_DATA_W-1:0] shift_reg;
  logic [SHP_ADDR_W-1:0] addr_reg;
  logic read_reg;
  logic [SHP_DATA_W-1:0] tx_reg;
  logic sdo_reg;
  logic oe_n_reg;
  logic wr_reg;
  logic rd_reg;
  logic [SHP_DATA_W-1:0] wdata_reg;
  logic [SHP_ADDR_W-1:0] addr_out_reg;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Every pin passes two flops before it is combined; select stages reset high
  // so the port stays released until the real pin levels have arrived
  shp_sync #(
    .WIDTH(4),
    .RESET_VAL(SHP_PIN_SYNC_RESET)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .d_i({host_port_select_i, cs_n_i, serial_bit_clock_i, serial_data_in_i}),
    .q_o(pins_sync)
  );

  // A high select (or host mode off) holds the port idle
  assign sel_n_s = pins_sync[3] | pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  wire active = !sel_n_s;
  wire rise = active && sclk_s && !sclk_d_reg;
  wire fall = active && !sclk_s && sclk_d_reg;
  wire byte_done = rise && (bit_reg == SHP_LAST_BIT);
  wire [SHP_DATA_W-1:0] rx_byte = {shift_reg[SHP_DATA_W-2:0], sdi_s};
  wire cmd_is_read = rx_byte[SHP_CMD_DIR_BIT] != SHP_DIR_WRITE;
  wire data_byte = byte_done && (state_reg == SHP_ST_DATA);
  wire load_tx = byte_done && (state_reg == SHP_ST_DUMMY) && read_reg;
  wire next_tx = data_byte && read_reg;
  wire [SHP_ADDR_W-1:0] addr_inc = addr_reg + 7'h01;
  // Read prefetch targets the next location once the current byte completes
  wire [SHP_ADDR_W-1:0] tx_addr = next_tx ? addr_inc : addr_reg;

  always_comb begin
    state_next = state_reg;
    if (byte_done) begin
      unique case (state_reg)
        SHP_ST_CMD: state_next = SHP_ST_DUMMY;
        SHP_ST_DUMMY: state_next = SHP_ST_DATA;
        SHP_ST_DATA: state_next = SHP_ST_DATA;
        default: state_next = SHP_ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= SHP_ST_CMD;
      bit_reg <= SHP_BIT_RESET;
      shift_reg <= SHP_BYTE_RESET;
    end else if (!active) begin
      state_reg <= SHP_ST_CMD;
      bit_reg <= SHP_BIT_RESET;
      shift_reg <= SHP_BYTE_RESET;
    end else if (rise) begin
      state_reg <= state_next;
      bit_reg <= bit_reg + 3'h1;
      shift_reg <= rx_byte;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_reg <= SHP_ADDR_RESET;
      read_reg <= 1'b0;
    end else if (byte_done && state_reg == SHP_ST_CMD) begin
      addr_reg <= rx_byte[SHP_ADDR_W-1:0];
      read_reg <= cmd_is_read;
    end else if (data_byte) begin
      addr_reg <= addr_inc;
    end
  end

  // Strobe qualifiers and the address presented with each strobe
  wire wr_take = data_byte && !read_reg;
  wire rd_take = load_tx || next_tx;
  wire addr_take = rd_take || wr_take;
  // A write reports the location just filled; a read the location to fetch
  wire [SHP_ADDR_W-1:0] strobe_addr = wr_take ? addr_reg : tx_addr;
  wire out_shift = fall && (state_reg == SHP_ST_DATA);
  wire out_bit = out_shift && read_reg;

  // Write strobe and read request, one cycle each
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= wr_take;
      rd_reg <= rd_take;
    end
  end

  // Write data stands until the next write
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdata_reg <= SHP_BYTE_RESET;
    end else if (wr_take) begin
      wdata_reg <= rx_byte;
    end
  end

  // Address stands until the next strobe
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_out_reg <= SHP_ADDR_RESET;
    end else if (addr_take) begin
      addr_out_reg <= strobe_addr;
    end
  end

  // Data out is released whenever the port is not selected
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= !active;
    end
  end

  // Read data is captured one cycle after the request, before the next falling edge
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_reg <= SHP_BYTE_RESET;
    end else if (!active) begin
      tx_reg <= SHP_BYTE_RESET;
    end else if (rd_reg) begin
      tx_reg <= reg_rdata_i;
    end else if (out_shift) begin
      tx_reg <= {tx_reg[SHP_DATA_W-2:0], 1'b0};
    end
  end

  // Data out moves after a falling serial clock edge, and returns low when the port is deselected
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sdo_reg <= 1'b0;
    end else if (!active) begin
      sdo_reg <= 1'b0;
    end else if (out_bit) begin
      sdo_reg <= tx_reg[SHP_DATA_W-1];
    end
  end

  assign serial_data_out_o = sdo_reg;
  assign serial_data_out_oe_n_o = oe_n_reg;
  assign reg_addr_o = addr_out_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_wr_o = wr_reg;
  assign reg_rd_o = rd_reg;
endmodule
`default_nettype wire

// File: verif/shp_host_port_monitor.sv
// Checker for the serial host port pins and strobes
`default_nettype none
module shp_host_port_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic host_port_select_i,
  input wire logic cs_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_n_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_OE_IDLE: assert property (cs_n_i [*4] |-> serial_data_out_oe_n_o) else $error("data out driven while idle");
  AST_WR_IDLE: assert property (cs_n_i [*4] |-> !reg_wr_o) else $error("write while deselected");
  AST_RD_IDLE: assert property (cs_n_i [*4] |-> !reg_rd_o) else $error("read while deselected");
  AST_SEL_IDLE: assert property (host_port_select_i [*4] |-> serial_data_out_oe_n_o && !reg_wr_o) else $error("port active");
  AST_ONE_STROBE: assert property (!(reg_wr_o && reg_rd_o)) else $error("read and write together");
  AST_WR_PULSE: assert property (reg_wr_o |=> !reg_wr_o) else $error("write strobe too long");
  AST_RD_PULSE: assert property (reg_rd_o |=> !reg_rd_o) else $error("read strobe too long");
  AST_OUT_ON_FALL: assert property (!serial_data_out_oe_n_o && $changed(serial_data_out_o) |-> !serial_bit_clock_i)
    else $error("data out moved with clock high");
endmodule
bind shp_host_port shp_host_port_monitor i_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .host_port_select_i(host_port_select_i), .cs_n_i(cs_n_i), .serial_bit_clock_i(serial_bit_clock_i),
  .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_n_o(serial_data_out_oe_n_o),
  .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o));
`default_nettype wire

// File: verif/shp_host_model.sv
// Serial host model driving select, clock and data
`default_nettype none
module shp_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  initial sdi_o = 1'b0;
  // 80 ns half period keeps the rate far below the ceiling
  task automatic half();
    repeat (10) @(posedge clk_i);
  endtask
  // Bytes go out top bit first, set up before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= tx[i];
      half();
      sclk_o <= 1'b1;
      rx[i] = sdo_i;
      half();
      sclk_o <= 1'b0;
    end
  endtask
  // Select spans the whole access; data line flips each time select is driven or released
  task automatic frame(input logic on);
    cs_n_o <= !on;
    sdi_o <= !sdi_o;
    half();
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Testbench for the serial host register port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import shp_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, sel = 1'b0, cs_n, sclk, sdi, sdo, oe_n, wr, rd;
  logic [6:0] addr;
  logic [7:0] wdata, r;
  logic [14:0] wq[$];
  logic [6:0] rq[$];
  int n_fail = 0, total_checks = 0;
  wire sdo_w = oe_n ? 1'b1 : sdo;
  always #4 clk_i = ~clk_i;
  // Register file model: data follows the presented address within the cycle
  wire [7:0] rdata = {1'b0, addr} ^ 8'hC3;
  always @(posedge clk_i) if (rd) rq.push_back(addr);
  always @(posedge clk_i) if (wr) wq.push_back({addr, wdata});
  shp_host_model i_host (.clk_i(clk_i), .sdo_i(sdo_w), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  shp_host_port i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .host_port_select_i(sel), .cs_n_i(cs_n),
    .serial_bit_clock_i(sclk), .serial_data_in_i(sdi), .serial_data_out_o(sdo), .serial_data_out_oe_n_o(oe_n),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_write();
    i_host.frame(1'b1);
    i_host.xfer(8'h05, r);
    i_host.xfer(8'hFF, r);
    i_host.xfer(8'hA5, r);
    i_host.xfer(8'h3C, r);
    i_host.frame(1'b0);
    check(15'(wq.size()), 15'h2);
    check(wq[0], {7'h05, 8'hA5});
    check(wq[1], {7'h06, 8'h3C});
  endtask
  task automatic t_read();
    i_host.frame(1'b1);
    i_host.xfer(8'h85, r);
    i_host.xfer(8'h00, r);
    for (int k = 0; k < 3; k++) begin
      i_host.xfer(8'h00, r);
      check({7'h00, r}, {7'h00, (8'h05 + 8'(k)) ^ 8'hC3});
    end
    i_host.frame(1'b0);
    check({14'h0, sdo_w}, 15'h1);
    check(15'(rq.size()), 15'h4);
    check({8'h00, rq[0]}, {8'h00, 7'h05});
    check({8'h00, rq[2]}, {8'h00, 7'h07});
  endtask
  task automatic t_idle();
    i_host.xfer(8'h05, r);
    i_host.xfer(8'h00, r);
    i_host.xfer(8'h77, r);
    sel <= 1'b1;
    i_host.frame(1'b1);
    i_host.xfer(8'h05, r);
    i_host.xfer(8'h00, r);
    i_host.xfer(8'h77, r);
    i_host.frame(1'b0);
    sel <= 1'b0;
    check(15'(wq.size()), 15'h2);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_write();
    t_read();
    t_idle();
    stop_test();
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
